// File: common/pattern_pkg.sv
// Shared constants, types and helpers for the digital pattern playback core
// Notes on behaviour
// - Each rising sample clock edge puts the next 32-bit buffer word on the outputs.
// - Internal sample clock is programmable between 1 Hz and 50 MHz.
// - External clock works from DC upward, may stop; source stays at most 50 MHz.
// - Looping replays the stored pattern a programmed number of times.
// - An endless loop setting repeats the pattern until software stops it.
// - Software trigger by a control register write, once or periodically.
// - Software selects the external trigger input as trigger source by control bits.
// - Software polarity bit chooses rising or falling external trigger edge.
// - Retriggerable mode outputs the programmed number of pattern loops per accepted trigger.
// - Retriggerable mode re-arms in hardware when the last programmed loop of the pattern ends.
// - Record lengths are at least 8 double words.
// - Record lengths are multiples of 2 double words.
// - Buffer depths up to 8M words; address counters cover 8M locations.
// - A master card passes all synchronisation signals to up to 7 slaves.
// - Master drives its sample clock out; slave takes sample clock from master.
// - Internal or external clock is chosen by software, no jumper.
// - Control window is four consecutive aligned word locations.
package pattern_pkg;

  // Clock and rate limits
  localparam int          CLK_HZ   = 200_000_000;
  localparam int          F_MAX_HZ = 50_000_000;
  localparam int          F_MIN_HZ = 1;
  localparam logic [31:0] DIV_MIN  = 32'(CLK_HZ / F_MAX_HZ);
  localparam logic [31:0] DIV_MAX  = 32'(CLK_HZ / F_MIN_HZ);

  // Buffer geometry
  localparam int          DATA_W        = 32;
  localparam int          ADDR_W        = 23;
  localparam int          LEN_W         = 24;
  localparam int          LOOP_W        = 16;
  localparam logic [23:0] BUF_WORDS_MAX = 24'h800000;
  localparam logic [23:0] LEN_MIN       = 24'h000008;
  localparam int          MAX_SLAVES    = 7;

  // Register offsets (four aligned words)
  localparam logic [7:0] OFF_CTRL  = 8'h00;
  localparam logic [7:0] OFF_LEN   = 8'h04;
  localparam logic [7:0] OFF_LOOPS = 8'h08;
  localparam logic [7:0] OFF_DIV   = 8'h0C;

  // Reset values
  localparam logic [31:0] CTRL_RST  = 32'h00000000;
  localparam logic [23:0] LEN_RST   = 24'h000008;
  localparam logic [31:0] LOOPS_RST = 32'h00000001;
  localparam logic [31:0] DIV_RST   = 32'h00000004;

  // Field positions of the loop register and status bits in the control read
  localparam int LOOP_CNT_LSB = 0;
  localparam int PERIOD_LSB   = 16;
  localparam int STAT_ARMED   = 16;
  localparam int STAT_BUSY    = 17;

  // Bus answers
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {ROLE_INDEP, ROLE_MASTER, ROLE_SLAVE, ROLE_RSVD} role_type;
  typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_RUN} play_state_type;

  // Control register layout, bit 0 at the bottom
  typedef struct packed {
    logic [21:0] unused;
    role_type    role;
    logic        trig_falling;
    logic        trig_ext;
    logic        ext_clk;
    logic        retrig;
    logic        periodic;
    logic        sw_trig;
    logic        arm;
    logic        run;
  } ctrl_type;

  // Byte-lane merge for write strobes
  function automatic logic [31:0] merge_bytes(input logic [31:0] old,
                                              input logic [31:0] nw,
                                              input logic [3:0]  strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) r[8*i +: 8] = nw[8*i +: 8];
    end
    return r;
  endfunction : merge_bytes

  // Force a record length even, not below the minimum, not above the buffer
  function automatic logic [23:0] legal_len(input logic [31:0] v);
    logic [31:0] e;
    e = {v[31:1], 1'b0};
    if (e < {8'h00, LEN_MIN}) e = {8'h00, LEN_MIN};
    if (e > {8'h00, BUF_WORDS_MAX}) e = {8'h00, BUF_WORDS_MAX};
    return e[23:0];
  endfunction : legal_len

  // Keep the divider inside the legal rate band
  function automatic logic [31:0] clamp_div(input logic [31:0] v);
    logic [31:0] e;
    e = v;
    if (e < DIV_MIN) e = DIV_MIN;
    if (e > DIV_MAX) e = DIV_MAX;
    return e;
  endfunction : clamp_div

endpackage : pattern_pkg

// File: hw/sync_edge.sv
// Two-flop synchroniser with edge detection for an asynchronous input
`timescale 1ns/10ps
module sync_edge (
  // Clock and reset
  input  wire logic clk,
  input  wire logic arst_n,
  // Asynchronous input
  input  wire logic async_in,
  // Synchronised level and one-cycle edge pulses
  output logic      level,
  output logic      rise,
  output logic      fall
);

  logic meta_reg;
  logic sync_reg;
  logic prev_reg;

  // The first flop feeds only the second, so metastability cannot spread
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      prev_reg <= 1'b0;
    end else begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  // Edges come from the synchronised copy only
  assign level = sync_reg;
  assign rise  = sync_reg & ~prev_reg;
  assign fall  = ~sync_reg & prev_reg;

endmodule : sync_edge

// File: hw/pattern_playback.sv
// Pattern playback core with AXI4-Lite control window
//
// Local design decisions: register access over AXI4-Lite and the register addresses.
`timescale 1ns/10ps
module pattern_playback (
  // Clock and reset
  input  wire logic                      clk,
  input  wire logic                      arst_n,
  // AXI4-Lite write channels
  input  wire logic [7:0]                s_axi_awaddr,
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  output logic [1:0]                     s_axi_bresp,
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  // AXI4-Lite read channels
  input  wire logic [7:0]                s_axi_araddr,
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  output logic [31:0]                    s_axi_rdata,
  output logic [1:0]                     s_axi_rresp,
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  // Pattern buffer read port, data one cycle after address
  output logic [pattern_pkg::ADDR_W-1:0] mem_addr,
  input  wire logic [pattern_pkg::DATA_W-1:0] mem_rdata,
  // Front-panel pins
  input  wire logic                      ext_clk_pin,
  input  wire logic                      ext_trig_pin,
  output logic [pattern_pkg::DATA_W-1:0] pattern_out,
  // Master/slave synchronisation
  input  wire logic                      sync_clk_in,
  input  wire logic                      sync_gate_in,
  output logic                           sync_clk_out,
  output logic                           sync_gate_out
);
  import pattern_pkg::*;

  // Bus slave state
  logic                 aw_held_reg, w_held_reg, bvalid_reg, rvalid_reg;
  logic [7:0]           aw_addr_reg;
  logic [31:0]          w_data_reg, rdata_reg;
  logic [3:0]           w_strb_reg;
  logic [1:0]           bresp_reg, rresp_reg;
  // Configuration
  ctrl_type             ctrl_reg;
  logic [LEN_W-1:0]     len_reg;
  logic [31:0]          loops_reg;
  logic [31:0]          div_reg;
  // Playback state
  play_state_type       state_reg, state_next;
  logic [ADDR_W-1:0]    addr_reg;
  logic [LOOP_W-1:0]    loop_cnt_reg, per_cnt_reg;
  logic [31:0]          div_cnt_reg;
  logic [DATA_W-1:0]    pattern_out_reg;
  logic                 sclk_d1_reg, sync_clk_out_reg, sync_gate_out_reg;

  // Synchronised pins
  logic ext_clk_rise, etrig_rise, etrig_fall, sclk_rise, sgate_rise;

  sync_edge u_ext_clk (.clk(clk), .arst_n(arst_n), .async_in(ext_clk_pin),
                       .level(), .rise(ext_clk_rise), .fall());
  sync_edge u_ext_trig (.clk(clk), .arst_n(arst_n), .async_in(ext_trig_pin),
                        .level(), .rise(etrig_rise), .fall(etrig_fall));
  sync_edge u_sync_clk (.clk(clk), .arst_n(arst_n), .async_in(sync_clk_in),
                        .level(), .rise(sclk_rise), .fall());
  sync_edge u_sync_gate (.clk(clk), .arst_n(arst_n), .async_in(sync_gate_in),
                         .level(), .rise(sgate_rise), .fall());

  // Write decode: one write performed once address and data are both held
  wire        do_write = aw_held_reg & w_held_reg & ~bvalid_reg;
  wire [7:0]  aw_word  = {aw_addr_reg[7:2], 2'b00};
  wire        wr_ctrl  = do_write & (aw_word == OFF_CTRL);
  wire        wr_len   = do_write & (aw_word == OFF_LEN);
  wire        wr_loops = do_write & (aw_word == OFF_LOOPS);
  wire        wr_div   = do_write & (aw_word == OFF_DIV);
  wire        wr_hit   = wr_ctrl | wr_len | wr_loops | wr_div;
  wire [31:0] ctrl_new = merge_bytes(32'(ctrl_reg), w_data_reg, w_strb_reg);
  wire        arm_req  = wr_ctrl & ctrl_new[1];
  wire        sw_trig  = wr_ctrl & ctrl_new[2];

  assign s_axi_awready = ~aw_held_reg;
  assign s_axi_wready  = ~w_held_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;

  // Write channels may arrive in either order; response after both
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      aw_held_reg <= 1'b0;
      w_held_reg  <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg  <= 32'h00000000;
      w_strb_reg  <= 4'h0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && !aw_held_reg) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_held_reg) begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held_reg <= 1'b0;
        w_held_reg  <= 1'b0;
        bvalid_reg  <= 1'b1;
        bresp_reg   <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_reg && s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // Configuration registers; arm and trigger bits act as pulses, never stored
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_reg  <= ctrl_type'(CTRL_RST);
      len_reg   <= LEN_RST;
      loops_reg <= LOOPS_RST;
      div_reg   <= DIV_RST;
    end else begin
      if (wr_ctrl) ctrl_reg <= ctrl_type'({ctrl_new[31:3], 2'b00, ctrl_new[0]});
      if (wr_len) len_reg <= legal_len(merge_bytes({8'h00, len_reg}, w_data_reg,
                                                   w_strb_reg));
      if (wr_loops) loops_reg <= merge_bytes(loops_reg, w_data_reg, w_strb_reg);
      if (wr_div) div_reg <= clamp_div(merge_bytes(div_reg, w_data_reg, w_strb_reg));
    end
  end

  // Read decode; unmapped words answer SLVERR with zero data
  wire [7:0]  ar_word = {s_axi_araddr[7:2], 2'b00};
  wire [31:0] ctrl_rd = {14'h0000, state_reg == ST_RUN, state_reg == ST_ARMED,
                         ctrl_reg[15:0]};
  wire        rd_hit  = (ar_word == OFF_CTRL) | (ar_word == OFF_LEN) |
                        (ar_word == OFF_LOOPS) | (ar_word == OFF_DIV);
  wire [31:0] rd_mux  = (ar_word == OFF_CTRL)  ? ctrl_rd :
                        (ar_word == OFF_LEN)   ? {8'h00, len_reg} :
                        (ar_word == OFF_LOOPS) ? loops_reg :
                        (ar_word == OFF_DIV)   ? div_reg : 32'h00000000;

  assign s_axi_arready = ~rvalid_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;

  // Read answer one cycle after the address is taken
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h00000000;
      rresp_reg  <= RESP_OKAY;
    end else if (s_axi_arvalid && !rvalid_reg) begin
      rvalid_reg <= 1'b1;
      rdata_reg  <= rd_mux;
      rresp_reg  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // Sample clock source: slave follows master, else external or divider
  wire role_slave  = (ctrl_reg.role == ROLE_SLAVE);
  wire role_master = (ctrl_reg.role == ROLE_MASTER);
  wire int_tick    = (div_cnt_reg >= div_reg - 32'h1);
  wire tick        = role_slave ? sclk_rise :
                     ctrl_reg.ext_clk ? ext_clk_rise : int_tick;

  // Free-running divider; compare by >= so a smaller new divider cannot stall it
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) div_cnt_reg <= 32'h00000000;
    else div_cnt_reg <= int_tick ? 32'h00000000 : div_cnt_reg + 32'h1;
  end

  // Trigger selection
  wire [LOOP_W-1:0] period    = loops_reg[PERIOD_LSB +: LOOP_W];
  wire [LOOP_W-1:0] loops_set = loops_reg[LOOP_CNT_LSB +: LOOP_W];
  wire trig_edge = ctrl_reg.trig_falling ? etrig_fall : etrig_rise;
  wire per_fire  = (state_reg == ST_ARMED) & ctrl_reg.periodic & tick &
                   ((period == 16'h0000) | (per_cnt_reg + 16'h1 >= period));
  wire trig_any  = role_slave ? sgate_rise :
                   ctrl_reg.trig_ext ? trig_edge : (sw_trig | per_fire);
  wire accept    = (state_reg == ST_ARMED) & trig_any & ctrl_reg.run;

  // End-of-record and end-of-run decode
  wire last_word  = tick & ({1'b0, addr_reg} == len_reg - 24'h1);
  wire endless    = (loops_set == 16'h0000);
  wire final_loop = ~endless & (loop_cnt_reg + 16'h1 >= loops_set);
  wire rearm      = ctrl_reg.retrig | ctrl_reg.periodic;

  // Playback sequencer
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (arm_req && ctrl_reg.run) state_next = ST_ARMED;
      end
      ST_ARMED: begin
        if (!ctrl_reg.run) state_next = ST_IDLE;
        else if (accept) state_next = ST_RUN;
      end
      ST_RUN: begin
        if (!ctrl_reg.run) state_next = ST_IDLE;
        else if (last_word && final_loop) begin
          state_next = rearm ? ST_ARMED : ST_IDLE;
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) state_reg <= ST_IDLE;
    else state_reg <= state_next;
  end

  // Address and loop counters; the address parks at zero when idle, so the
  // first word is already fetched when the next trigger comes
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      addr_reg     <= '0;
      loop_cnt_reg <= '0;
    end else if (state_reg != ST_RUN || !ctrl_reg.run) begin
      addr_reg     <= '0;
      loop_cnt_reg <= '0;
    end else if (tick) begin
      addr_reg     <= last_word ? '0 : addr_reg + 23'h1;
      loop_cnt_reg <= last_word ? loop_cnt_reg + 16'h1 : loop_cnt_reg;
    end
  end

  // Output word changes only on a sample edge while running
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) pattern_out_reg <= '0;
    else if (state_reg == ST_RUN && ctrl_reg.run && tick) pattern_out_reg <= mem_rdata;
  end

  // Periodic software trigger counts sample edges while armed
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) per_cnt_reg <= '0;
    else if (state_reg != ST_ARMED || per_fire) per_cnt_reg <= '0;
    else if (tick) per_cnt_reg <= per_cnt_reg + 16'h1;
  end

  // Master drives a two-cycle-wide clock pulse and a gate; slaves see both
  // through their own synchronisers, a fixed skew of a few cycles
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sclk_d1_reg       <= 1'b0;
      sync_clk_out_reg  <= 1'b0;
      sync_gate_out_reg <= 1'b0;
    end else begin
      sclk_d1_reg       <= tick;
      sync_clk_out_reg  <= role_master & (tick | sclk_d1_reg);
      sync_gate_out_reg <= role_master & (state_reg == ST_RUN);
    end
  end

  assign mem_addr      = addr_reg;
  assign pattern_out   = pattern_out_reg;
  assign sync_clk_out  = sync_clk_out_reg;
  assign sync_gate_out = sync_gate_out_reg;

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  sequence idle_pair;
    state_reg != ST_RUN ##1 state_reg != ST_RUN;
  endsequence

  sequence start_run;
    state_reg == ST_RUN && addr_reg == '0 && loop_cnt_reg == '0;
  endsequence

  out_on_tick_a: assert property (state_reg == ST_RUN && ctrl_reg.run && tick |=>
    pattern_out_reg == $past(mem_rdata)) else $error("word not sent on sample edge");
  div_range_a: assert property (div_reg >= DIV_MIN && div_reg <= DIV_MAX)
    else $error("divider out of range");
  ext_tick_a: assert property (ctrl_reg.ext_clk && !role_slave && ext_clk_rise
    |-> tick) else $error("external edge missed");
  loop_end_a: assert property (state_reg == ST_RUN && ctrl_reg.run && last_word &&
    final_loop |=> state_reg != ST_RUN) else $error("run did not end after loops");
  endless_a: assert property (state_reg == ST_RUN && ctrl_reg.run && endless
    |=> state_reg == ST_RUN) else $error("endless run stopped");
  trig_start_a: assert property (accept |=> start_run)
    else $error("trigger did not start pattern");
  ext_trig_a: assert property (state_reg == ST_ARMED && ctrl_reg.run && !role_slave &&
    ctrl_reg.trig_ext && trig_edge |=> state_reg == ST_RUN) else $error("ext trigger lost");
  polarity_a: assert property (ctrl_reg.trig_ext && !role_slave && ctrl_reg.trig_falling
    && etrig_rise && !etrig_fall |-> !trig_any) else $error("wrong trigger edge");
  rearm_a: assert property (state_reg == ST_RUN && ctrl_reg.run && last_word &&
    final_loop && ctrl_reg.retrig |=> state_reg == ST_ARMED) else $error("no re-arm");
  len_legal_a: assert property (len_reg >= LEN_MIN && !len_reg[0] &&
    len_reg <= BUF_WORDS_MAX) else $error("illegal record length");
  ignore_a: assert property (state_reg == ST_RUN && ctrl_reg.run && trig_any &&
    !tick |=> $stable(addr_reg)) else $error("trigger disturbed running pattern");
  hold_a: assert property (idle_pair |-> $stable(pattern_out_reg) && addr_reg == '0)
    else $error("output moved while stopped");
  master_clk_a: assert property (role_master && tick ##1 role_master |->
    sync_clk_out_reg ##1 sync_clk_out_reg) else $error("master clock pulse missing");

endmodule : pattern_playback

// File: tb/pattern_source_model.sv
// Synchronous pattern buffer model standing in for the on-board memory
`timescale 1ns/10ps
module pattern_source_model (
  // Clock
  input  wire logic        clk,
  // Read port and content seed
  input  wire logic [22:0] mem_addr,
  input  wire logic [31:0] base,
  output logic      [31:0] mem_rdata
);
  // One-cycle read; seed xor address keeps neighbouring words distinct
  always_ff @(posedge clk) begin
    mem_rdata <= base ^ {9'h000, mem_addr};
  end
endmodule : pattern_source_model

// File: tb/digital_pattern_playback_tb.sv
// Self-checking bench for the pattern playback core
`timescale 1ns/10ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin fails++; \
  $display("[ERR] %s exp %h got %h", nm, e, g); end end
module digital_pattern_playback_tb;
  import pattern_pkg::*;
  // Bench-driven inputs
  logic        clk = 1'b0, arst_n = 1'b0, link_clk = 1'b0, link_on = 1'b0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        trig = 1'b0, gate = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h00000000, base = 32'h00000000, rnd = 32'h00001847;
  // Design outputs and scoreboard state
  logic        awready, wready, bvalid, arready, rvalid, gate_o, clk_o, ck;
  logic [1:0]  bresp, rresp, eb;
  logic [22:0] mem_addr;
  logic [31:0] mem_rdata, pattern_out, rdata, ep, last_pat = 32'h00000000;
  logic [33:0] er;
  logic [31:0] pq[$];
  logic [33:0] rq[$];
  logic [1:0]  bq[$];
  int          fails = 0, compares = 0, len = 8;
  // Core under test and its buffer
  pattern_playback dut (.clk(clk), .arst_n(arst_n), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .mem_addr(mem_addr), .mem_rdata(mem_rdata), .ext_clk_pin(link_clk),
    .ext_trig_pin(trig), .pattern_out(pattern_out), .sync_clk_in(link_clk),
    .sync_gate_in(gate), .sync_clk_out(clk_o), .sync_gate_out(gate_o));
  pattern_source_model far (.clk(clk), .mem_addr(mem_addr), .base(base),
    .mem_rdata(mem_rdata));
  // System clock, and a link clock that only runs inside frames
  initial forever #2.5 clk = ~clk;
  initial forever #24 if (link_on) link_clk = ~link_clk; // 48 ns, under the ceiling
  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] x;
    x = v ^ (v << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs
  // Write: both channels offered together, each released once taken
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    bq.push_back(r);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid && n < 64);
    if (!bvalid) fails++; // A stuck write counts as a mismatch
    bready <= 1'b0;
  endtask : axw
  task automatic axr(input logic [7:0] a, input logic [33:0] e);
    int n;
    rq.push_back(e);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (!rvalid && n < 64);
    if (!rvalid) fails++; // A stuck read counts as a mismatch
    rready <= 1'b0;
  endtask : axr
  task automatic drain(input int left);
    int n;
    n = 0;
    while (pq.size() > left && n < 4000) begin
      @(posedge clk);
      n++;
    end
    if (pq.size() > left) fails++; // Words that never came out
  endtask : drain
  // One playback: refused triggers first, then the real one; pattern noted in advance
  task automatic play(input logic [31:0] c, input int loops);
    int total;
    total = (loops ? loops : 2) * len;
    rnd = xs(rnd);
    base <= rnd;
    trig <= ~c[7];
    gate <= 1'b0;
    axw(OFF_CTRL, 32'h0, RESP_OKAY);
    axw(OFF_LOOPS, loops, RESP_OKAY);
    axw(OFF_CTRL, c | 32'h5, RESP_OKAY); // not armed, so ignored
    repeat (20) @(posedge clk);
    axw(OFF_CTRL, c | 32'h3, RESP_OKAY);
    trig <= c[7]; // opposite edge must not start
    repeat (20) @(posedge clk);
    for (int k = 0; k < total; k++) pq.push_back(rnd ^ (k % len));
    link_on = c[5] | c[9];
    trig <= ~c[7];
    gate <= 1'b1;
    if (!c[6]) axw(OFF_CTRL, c | 32'h5, RESP_OKAY);
    drain(total - 2);
    `CHK("gate_out", c[9:8] == 2'b01, gate_o)
    ck = 1'b0;
    repeat (4) begin
      @(posedge clk);
      ck = ck | clk_o;
    end
    `CHK("clk_out", c[9:8] == 2'b01, ck)
    if (!c[6]) axw(OFF_CTRL, c | 32'h5, RESP_OKAY); // busy, so ignored
    if (link_on) begin
      drain(total - len);
      link_on = 0; // clock halts once the first record is out, then resumes
      repeat (30) @(posedge clk);
      link_on = 1;
    end
    drain(0);
    link_on = 0;
    if (!loops) axw(OFF_CTRL, 32'h0, RESP_OKAY); // endless run stops only by software
    repeat (40) @(posedge clk);
    axr(OFF_CTRL, {RESP_OKAY, 15'h0, loops != 0 && c[4], loops ? c[15:0] | 16'h1 : 16'h0});
  endtask : play
  // Scoreboard: each observed result against the oldest note
  always @(posedge clk) begin
    if (rvalid && rready) begin
      er = rq.size() ? rq.pop_front() : 'x;
      `CHK("rdata", er, {rresp, rdata})
    end
    if (bvalid && bready) begin
      eb = bq.size() ? bq.pop_front() : 'x;
      `CHK("bresp", eb, bresp)
    end
    if (arst_n && pattern_out !== last_pat) begin
      ep = pq.size() ? pq.pop_front() : 'x;
      `CHK("pattern", ep, pattern_out)
      last_pat = pattern_out;
    end
  end
  task automatic wrap_up;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : wrap_up
  // Cut a hang short
  initial begin
    repeat (60000) @(posedge clk);
    fails++;
    wrap_up();
  end
  // Main sequence
  initial begin
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    axr(OFF_CTRL, {RESP_OKAY, CTRL_RST});
    axr(OFF_LEN, {RESP_OKAY, 8'h00, LEN_RST});
    axr(OFF_LOOPS, {RESP_OKAY, LOOPS_RST});
    axr(OFF_DIV, {RESP_OKAY, DIV_RST});
    axw(8'h10, 32'h1, RESP_SLVERR);
    axr(8'h10, {RESP_SLVERR, 32'h0});
    axw(OFF_DIV, 32'h1, RESP_OKAY);
    axr(OFF_DIV, {RESP_OKAY, DIV_MIN});
    axw(OFF_DIV, 32'hFFFFFFFF, RESP_OKAY);
    axr(OFF_DIV, {RESP_OKAY, DIV_MAX});
    axw(OFF_DIV, 32'h4, RESP_OKAY);
    axw(OFF_LEN, 32'h00FFFFFF, RESP_OKAY);
    axr(OFF_LEN, {RESP_OKAY, 8'h00, BUF_WORDS_MAX});
    repeat (3) begin
      rnd = xs(rnd);
      len = rnd[4:1] < 4 ? 8 : 2 * rnd[4:1];
      axw(OFF_LEN, {27'h0, rnd[4:0]}, RESP_OKAY);
      axr(OFF_LEN, {RESP_OKAY, 32'(len)});
    end
    play(32'h00000000, 2);
    play(32'h00000100, 1);
    // Retriggerable runs on either trigger edge, then a second pattern without software
    for (int p = 0; p < 2; p++) begin
      play({24'h0, p[0], 7'h50}, 1);
      trig <= p[0];
      repeat (20) @(posedge clk);
      for (int k = 0; k < len; k++) pq.push_back(rnd ^ k);
      trig <= ~p[0];
      drain(0);
    end
    // Periodic software trigger: two patterns, each after 16 sample ticks armed
    axw(OFF_CTRL, 32'h0, RESP_OKAY);
    axw(OFF_LOOPS, 32'h00100001, RESP_OKAY);
    for (int k = 0; k < 2 * len; k++) pq.push_back(rnd ^ (k % len));
    axw(OFF_CTRL, 32'h9, RESP_OKAY);
    axw(OFF_CTRL, 32'hB, RESP_OKAY);
    drain(0);
    axw(OFF_CTRL, 32'h0, RESP_OKAY);
    play(32'h00000020, 0);
    play(32'h00000200, 1);
    repeat (2) @(posedge clk);
    if (pq.size() || rq.size() || bq.size()) fails++; // Notes never matched
    wrap_up();
  end
endmodule : digital_pattern_playback_tb
